// ==== bench/branch_and_bitset_exec_bench.sv ====
// Self-checking bench for the branch and bit-set executor, driven over APB
`timescale 1ns/1ps
`include "bbe_cfg.svh"
module branch_and_bitset_exec_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        er;
    int          err_total;
    int          comparisons;
    int          cycles = 0;

    typedef struct packed {
        logic        ctrl;
        logic [15:0] instr;
        logic [4:0]  st;
        logic [20:0] pc0;
        logic [20:0] pc_exp;
        logic [1:0]  cyc;
        logic [11:0] fa;
        logic [7:0]  fd0;
        logic [7:0]  fd_exp;
    } bbe_row_s;

    // Taken and untaken branches at offset limits, non-branch codes, each addressing mode
    bbe_row_s rows [14] = '{
        '{1'h0, 16'hE105, 5'h1B, 21'h000100, 21'h00010C, 2'h2, 12'h123, 8'h55, 8'h55},
        '{1'h0, 16'hE105, 5'h04, 21'h000100, 21'h000102, 2'h1, 12'h123, 8'h55, 8'h55},
        '{1'h0, 16'hE180, 5'h1B, 21'h000100, 21'h000002, 2'h2, 12'h123, 8'h55, 8'h55},
        '{1'h0, 16'hE17F, 5'h1B, 21'h000100, 21'h000200, 2'h2, 12'h123, 8'h55, 8'h55},
        '{1'h0, 16'hD3FF, 5'h04, 21'h001000, 21'h001800, 2'h2, 12'h123, 8'h55, 8'h55},
        '{1'h0, 16'hD400, 5'h1B, 21'h001000, 21'h000802, 2'h2, 12'h123, 8'h55, 8'h55},
        '{1'h0, 16'hD800, 5'h1B, 21'h001000, 21'h001002, 2'h1, 12'h123, 8'h55, 8'h55},
        '{1'h0, 16'hE300, 5'h1B, 21'h000100, 21'h000102, 2'h1, 12'h123, 8'h55, 8'h55},
        '{1'h0, 16'h8F45, 5'h1B, 21'h000040, 21'h000042, 2'h1, 12'h345, 8'h0A, 8'h8A},
        '{1'h0, 16'h8020, 5'h04, 21'h000040, 21'h000042, 2'h1, 12'h020, 8'h00, 8'h01},
        '{1'h0, 16'h8660, 5'h1B, 21'h000040, 21'h000042, 2'h1, 12'hF60, 8'h00, 8'h08},
        '{1'h1, 16'h825F, 5'h1B, 21'h000040, 21'h000042, 2'h1, 12'h25F, 8'h00, 8'h02},
        '{1'h1, 16'h8860, 5'h1B, 21'h000040, 21'h000042, 2'h1, 12'hF60, 8'h01, 8'h11},
        '{1'h1, 16'h8F45, 5'h04, 21'h000040, 21'h000042, 2'h1, 12'h345, 8'h00, 8'h80}
    };
    logic [11:0] rst_regs [7] = '{`BBE_OFF_CTRL, `BBE_OFF_PC, `BBE_OFF_STATUS, `BBE_OFF_BANK,
                                  `BBE_OFF_IDXBASE, `BBE_OFF_FADDR, `BBE_OFF_EXSTAT};

    bbe_exec bbe_exec_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    task automatic final_report;
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One full transfer; read data and error are taken at the pready edge only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk(32'h0, 32'h1);
        end
    endtask

    // Busy must be polled; a new instruction while busy is refused
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            apb(1'b0, `BBE_OFF_EXSTAT, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 10);
        chk({31'h0, rd[0]}, 32'h0);
    endtask

    task automatic execute(input logic [15:0] ins);
        apb(1'b1, `BBE_OFF_INSTR, {16'h0000, ins});
        chk({31'h0, er}, 32'h0);
        wait_idle();
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        err_total   = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, `BBE_OFF_CTRL, {31'h0, rows[i].ctrl});
            apb(1'b1, `BBE_OFF_BANK, 32'h3);
            apb(1'b1, `BBE_OFF_IDXBASE, 32'h200);
            apb(1'b1, `BBE_OFF_PC, {11'h0, rows[i].pc0});
            apb(1'b1, `BBE_OFF_STATUS, {27'h0, rows[i].st});
            apb(1'b1, `BBE_OFF_FADDR, {20'h0, rows[i].fa});
            apb(1'b1, `BBE_OFF_FDATA, {24'h0, rows[i].fd0});
            execute(rows[i].instr);
            chk({30'h0, rd[5:4]}, {30'h0, rows[i].cyc});
            apb(1'b0, `BBE_OFF_PC, 32'h0);
            chk(rd, {11'h0, rows[i].pc_exp});
            apb(1'b0, `BBE_OFF_STATUS, 32'h0);
            chk(rd, {27'h0, rows[i].st});
            apb(1'b0, `BBE_OFF_FDATA, 32'h0);
            chk(rd, {24'h0, rows[i].fd_exp});
        end
        apb(1'b0, 12'h024, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 12'h024, 32'h1);
        chk({31'h0, er}, 32'h1);
        // Requests during a taken branch must bounce and leave its target intact
        apb(1'b1, `BBE_OFF_PC, 32'h100);
        apb(1'b1, `BBE_OFF_STATUS, 32'h1B);
        apb(1'b1, `BBE_OFF_INSTR, 32'hE105);
        apb(1'b1, `BBE_OFF_INSTR, 32'hD3FF);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, `BBE_OFF_PC, 32'h777);
        chk({31'h0, er}, 32'h1);
        // The flush can still be running here, so wait it out before the next instruction
        wait_idle();
        chk({30'h0, rd[5:4]}, 32'h2);
        execute(16'hFFFF);
        apb(1'b0, `BBE_OFF_PC, 32'h0);
        chk(rd, 32'h10E);
        // Second reset while idle clears every register except the file memory behind FDATA
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_regs[j]) begin
            apb(1'b0, rst_regs[j], 32'h0);
            chk(rd, 32'h0);
        end
        final_report();
    end
endmodule

// ==== hw/bbe_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the branch and bit-set executor
`ifndef BBE_CFG_SVH
`define BBE_CFG_SVH

// APB register byte offsets
`define BBE_OFF_CTRL      12'h000
`define BBE_OFF_INSTR     12'h004
`define BBE_OFF_PC        12'h008
`define BBE_OFF_STATUS    12'h00C
`define BBE_OFF_BANK      12'h010
`define BBE_OFF_IDXBASE   12'h014
`define BBE_OFF_FADDR     12'h018
`define BBE_OFF_FDATA     12'h01C
`define BBE_OFF_EXSTAT    12'h020

// Widths
`define BBE_PC_W          21
`define BBE_FA_W          12
`define BBE_STATUS_W      5
`define BBE_BANK_W        4

// Field positions
`define BBE_CTRL_EXT_BIT  0
`define BBE_ST_ZERO_BIT   2
`define BBE_EX_BUSY_BIT   0
`define BBE_EX_FLUSH_BIT  1
`define BBE_EX_CYC_LSB    4

// Opcode patterns
`define BBE_OP_BNZ        8'hE1
`define BBE_OP_BRA        5'h1A
`define BBE_OP_BSF        4'h8

// Access bank split and indexed literal limit
`define BBE_ACC_SPLIT     8'h60
`define BBE_IDX_LIMIT     8'h5F
`define BBE_ACC_HI_BANK   4'hF

// Reset values
`define BBE_RST_CTRL      1'h0
`define BBE_RST_STATUS    5'h00
`define BBE_RST_BANK      4'h0
`define BBE_RST_PC        21'h000000

// Last quarter phase of the instruction cycle, cycle counts and program counter step
`define BBE_Q_LAST        2'h3
`define BBE_CYC_ONE       2'h1
`define BBE_CYC_TWO       2'h2
`define BBE_PC_STEP       21'h000002

`endif

// ==== hw/bbe_exec.sv ====
// Branch-if-zero-clear, relative branch and set-file-bit executor with an APB register file
//
// What this block does
// - Branch-if-zero-clear loads the program counter with the incremented address plus twice a signed 8-bit offset only when the zero flag is 0.
// - Branch-if-zero-clear is decoded from upper byte 1110 0001, the low byte being the signed word offset.
// - Branch-if-zero-clear takes one instruction cycle when not taken and two when taken.
// - A taken conditional branch spends its second instruction cycle doing nothing in all four phases, discarding the prefetch.
// - Branch-if-zero-clear leaves every status flag unchanged.
// - The relative branch always loads the incremented address plus twice a signed 11-bit offset.
// - The relative branch is decoded from top nibble 1101 and a zero bit, the other eleven bits being the offset.
// - The relative branch always takes two cycles, writing the program counter in Q4 of the first and idling in the second.
// - Set-file-bit (top nibble 1000, fields bbb and a) forces bit b of file register f to one and leaves status flags alone.
// - With access bit 0 the file register is taken from the access bank.
// - With access bit 1 the bank number comes from the bank select register.
// - With the extended set enabled and access bit 0, file addresses up to 5Fh are indexed literal offsets.
`timescale 1ns/1ps
`include "bbe_cfg.svh"
module bbe_exec #(
    parameter int FILE_AW = `BBE_FA_W
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr
);
    logic [1:0]                phase;
    logic                      q4_mark;
    bbe_pkg::bbe_state_e       state_q;
    bbe_pkg::bbe_class_e       cls_q;
    logic                      ext_q;
    logic [15:0]               instr_q;
    logic                      pend_q;
    logic [`BBE_PC_W-1:0]      pc_q;
    logic [`BBE_PC_W-1:0]      pc_inc_q;
    logic [`BBE_PC_W-1:0]      target_q;
    logic                      taken_q;
    logic [`BBE_STATUS_W-1:0]  status_q;
    logic [`BBE_BANK_W-1:0]    bank_q;
    logic [FILE_AW-1:0]        idx_base_q;
    logic [FILE_AW-1:0]        faddr_q;
    logic [FILE_AW-1:0]        eaddr_q;
    logic [7:0]                rdata_q;
    logic [7:0]                wdata_q;
    logic [1:0]                last_cyc_q;
    logic [7:0]                mem [0:(1<<FILE_AW)-1];
    logic                      mem_we;
    logic                      busy;
    logic                      setup;
    logic                      acc_wr;
    logic                      mapped;
    logic                      refuse;
    logic [31:0]               rd_mux;
    logic [FILE_AW-1:0]        eaddr_d;

    bbe_quarter #(.QW(2)) bbe_quarter_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .phase_q (phase),
        .last_q  (q4_mark)
    );

    assign busy   = pend_q || (state_q != bbe_pkg::BBE_ST_IDLE);
    assign setup  = psel && !penable;
    assign pready = 1'b1;
    assign mapped = (paddr == `BBE_OFF_CTRL) || (paddr == `BBE_OFF_INSTR) ||
                    (paddr == `BBE_OFF_PC) || (paddr == `BBE_OFF_STATUS) ||
                    (paddr == `BBE_OFF_BANK) || (paddr == `BBE_OFF_IDXBASE) ||
                    (paddr == `BBE_OFF_FADDR) || (paddr == `BBE_OFF_FDATA) ||
                    (paddr == `BBE_OFF_EXSTAT);
    // Writes that would race the executor are refused rather than silently reordered
    assign refuse = pwrite && busy &&
                    ((paddr == `BBE_OFF_INSTR) || (paddr == `BBE_OFF_PC) ||
                     (paddr == `BBE_OFF_FDATA));
    assign pslverr = psel && penable && (!mapped || refuse);
    assign acc_wr  = psel && penable && pwrite && mapped && !refuse;
    assign mem_we  = (state_q == bbe_pkg::BBE_ST_EXEC) && q4_mark &&
                     (cls_q == bbe_pkg::BBE_CL_BSF);

    // Effective file address from access bit, bank select and extended mode
    always_comb begin
        eaddr_d = {bank_q, instr_q[7:0]};
        if (!instr_q[8]) begin
            if (ext_q && (instr_q[7:0] <= `BBE_IDX_LIMIT)) begin
                eaddr_d = idx_base_q + {{(FILE_AW-8){1'b0}}, instr_q[7:0]};
            end else if (instr_q[7:0] < `BBE_ACC_SPLIT) begin
                eaddr_d = {{(FILE_AW-8){1'b0}}, instr_q[7:0]};
            end else begin
                eaddr_d = {`BBE_ACC_HI_BANK, instr_q[7:0]};
            end
        end else begin
            eaddr_d = {bank_q, instr_q[7:0]};
        end
    end

    // Sequencer: idle waits for Q4 so execution starts on Q1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= bbe_pkg::BBE_ST_IDLE;
        end else begin
            case (state_q)
                bbe_pkg::BBE_ST_IDLE: begin
                    if (pend_q && phase == `BBE_Q_LAST) begin
                        state_q <= bbe_pkg::BBE_ST_EXEC;
                    end
                end
                bbe_pkg::BBE_ST_EXEC: begin
                    if (phase == `BBE_Q_LAST) begin
                        state_q <= taken_q ? bbe_pkg::BBE_ST_FLUSH
                                           : bbe_pkg::BBE_ST_IDLE;
                    end
                end
                bbe_pkg::BBE_ST_FLUSH: begin
                    if (phase == `BBE_Q_LAST) begin
                        state_q <= bbe_pkg::BBE_ST_IDLE;
                    end
                end
                default: state_q <= bbe_pkg::BBE_ST_IDLE;
            endcase
        end
    end

    // Pending instruction: set by an APB write, taken at the start of execution
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q  <= 1'b0;
            instr_q <= 16'h0000;
        end else if (acc_wr && paddr == `BBE_OFF_INSTR) begin
            pend_q  <= 1'b1;
            instr_q <= pwdata[15:0];
        end else if (state_q == bbe_pkg::BBE_ST_IDLE && phase == `BBE_Q_LAST) begin
            pend_q  <= 1'b0;
        end
    end

    // Q1 decode, Q2 read, Q3 process
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cls_q    <= bbe_pkg::BBE_CL_NONE;
            pc_inc_q <= `BBE_RST_PC;
            eaddr_q  <= '0;
            rdata_q  <= 8'h00;
            wdata_q  <= 8'h00;
            target_q <= `BBE_RST_PC;
            taken_q  <= 1'b0;
        end else if (state_q == bbe_pkg::BBE_ST_EXEC) begin
            case (phase)
                2'h0: begin
                    pc_inc_q <= pc_q + `BBE_PC_STEP;
                    eaddr_q  <= eaddr_d;
                    taken_q  <= 1'b0;
                    if (instr_q[15:8] == `BBE_OP_BNZ) begin
                        cls_q <= bbe_pkg::BBE_CL_BNZ;
                    end else if (instr_q[15:11] == `BBE_OP_BRA) begin
                        cls_q <= bbe_pkg::BBE_CL_BRA;
                    end else if (instr_q[15:12] == `BBE_OP_BSF) begin
                        cls_q <= bbe_pkg::BBE_CL_BSF;
                    end else begin
                        cls_q <= bbe_pkg::BBE_CL_NONE;
                    end
                end
                2'h1: begin
                    rdata_q <= mem[eaddr_q];
                end
                2'h2: begin
                    wdata_q <= rdata_q | (8'h01 << instr_q[11:9]);
                    if (cls_q == bbe_pkg::BBE_CL_BNZ) begin
                        target_q <= pc_inc_q + {{12{instr_q[7]}}, instr_q[7:0], 1'b0};
                        taken_q  <= !status_q[`BBE_ST_ZERO_BIT];
                    end else if (cls_q == bbe_pkg::BBE_CL_BRA) begin
                        target_q <= pc_inc_q + {{9{instr_q[10]}}, instr_q[10:0], 1'b0};
                        taken_q  <= 1'b1;
                    end else begin
                        target_q <= pc_inc_q;
                        taken_q  <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Program counter: written in Q4 of the first cycle, or by software while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= `BBE_RST_PC;
        end else if (state_q == bbe_pkg::BBE_ST_EXEC && phase == `BBE_Q_LAST) begin
            pc_q <= taken_q ? target_q : pc_inc_q;
        end else if (acc_wr && paddr == `BBE_OFF_PC) begin
            pc_q <= pwdata[`BBE_PC_W-1:0];
        end
    end

    // Cycle count of the last instruction, for software and the bench
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cyc_q <= 2'h0;
        end else if (state_q == bbe_pkg::BBE_ST_EXEC && phase == `BBE_Q_LAST) begin
            last_cyc_q <= taken_q ? `BBE_CYC_TWO : `BBE_CYC_ONE;
        end
    end

    // File memory: executor writes in Q4; software pokes only while idle
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[eaddr_q] <= wdata_q;
        end else if (acc_wr && paddr == `BBE_OFF_FDATA) begin
            mem[faddr_q] <= pwdata[7:0];
        end
    end

    // Software-owned registers; the executor never writes status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q      <= `BBE_RST_CTRL;
            status_q   <= `BBE_RST_STATUS;
            bank_q     <= `BBE_RST_BANK;
            idx_base_q <= '0;
            faddr_q    <= '0;
        end else if (acc_wr) begin
            if (paddr == `BBE_OFF_CTRL) begin
                ext_q <= pwdata[`BBE_CTRL_EXT_BIT];
            end else if (paddr == `BBE_OFF_STATUS) begin
                status_q <= pwdata[`BBE_STATUS_W-1:0];
            end else if (paddr == `BBE_OFF_BANK) begin
                bank_q <= pwdata[`BBE_BANK_W-1:0];
            end else if (paddr == `BBE_OFF_IDXBASE) begin
                idx_base_q <= pwdata[FILE_AW-1:0];
            end else if (paddr == `BBE_OFF_FADDR) begin
                faddr_q <= pwdata[FILE_AW-1:0];
            end
        end
    end

    // Read mux; captured in the setup phase so prdata is a flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == `BBE_OFF_CTRL) begin
            rd_mux[`BBE_CTRL_EXT_BIT] = ext_q;
        end else if (paddr == `BBE_OFF_INSTR) begin
            rd_mux[15:0] = instr_q;
        end else if (paddr == `BBE_OFF_PC) begin
            rd_mux[`BBE_PC_W-1:0] = pc_q;
        end else if (paddr == `BBE_OFF_STATUS) begin
            rd_mux[`BBE_STATUS_W-1:0] = status_q;
        end else if (paddr == `BBE_OFF_BANK) begin
            rd_mux[`BBE_BANK_W-1:0] = bank_q;
        end else if (paddr == `BBE_OFF_IDXBASE) begin
            rd_mux[FILE_AW-1:0] = idx_base_q;
        end else if (paddr == `BBE_OFF_FADDR) begin
            rd_mux[FILE_AW-1:0] = faddr_q;
        end else if (paddr == `BBE_OFF_FDATA) begin
            rd_mux[7:0] = mem[faddr_q];
        end else if (paddr == `BBE_OFF_EXSTAT) begin
            rd_mux[`BBE_EX_BUSY_BIT]  = busy;
            rd_mux[`BBE_EX_FLUSH_BIT] = (state_q == bbe_pkg::BBE_ST_FLUSH);
            rd_mux[`BBE_EX_CYC_LSB+1:`BBE_EX_CYC_LSB] = last_cyc_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Checks
    sequence exec_q4_s;
        state_q == bbe_pkg::BBE_ST_EXEC && phase == `BBE_Q_LAST;
    endsequence

    sequence flush_cycle_s;
        (state_q == bbe_pkg::BBE_ST_FLUSH && !mem_we) [*4];
    endsequence

    bnz_taken_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
        (exec_q4_s and cls_q == bbe_pkg::BBE_CL_BNZ and !status_q[`BBE_ST_ZERO_BIT])
        |=> pc_q == $past(pc_inc_q) + {{12{instr_q[7]}}, instr_q[7:0], 1'b0})
        else $error("zero-clear branch target wrong");

    bnz_skip_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
        (exec_q4_s and cls_q == bbe_pkg::BBE_CL_BNZ and status_q[`BBE_ST_ZERO_BIT])
        |=> pc_q == $past(pc_inc_q) && state_q == bbe_pkg::BBE_ST_IDLE)
        else $error("zero-set branch did not fall through");

    bnz_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == bbe_pkg::BBE_ST_EXEC && phase == 2'h1)
        |-> ((cls_q == bbe_pkg::BBE_CL_BNZ) == (instr_q[15:8] == `BBE_OP_BNZ)))
        else $error("zero-clear branch decode mismatch");

    taken_two_cyc_a: assert property (@(posedge pclk) disable iff (!presetn)
        (exec_q4_s and taken_q) |=> flush_cycle_s ##1 state_q == bbe_pkg::BBE_ST_IDLE)
        else $error("taken branch not exactly two cycles");

    flush_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == bbe_pkg::BBE_ST_FLUSH) |=> $stable(pc_q) && !mem_we)
        else $error("activity during discarded cycle");

    status_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && !acc_wr) |=> $stable(status_q))
        else $error("status changed by execution");

    bra_target_a: assert property (@(posedge pclk) disable iff (!presetn)
        (exec_q4_s and cls_q == bbe_pkg::BBE_CL_BRA)
        |=> pc_q == $past(pc_inc_q) + {{9{instr_q[10]}}, instr_q[10:0], 1'b0})
        else $error("relative branch target wrong");

    bra_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == bbe_pkg::BBE_ST_EXEC && phase == 2'h1)
        |-> ((cls_q == bbe_pkg::BBE_CL_BRA) == (instr_q[15:11] == `BBE_OP_BRA)))
        else $error("relative branch decode mismatch");

    bra_two_cyc_a: assert property (@(posedge pclk) disable iff (!presetn)
        (exec_q4_s and cls_q == bbe_pkg::BBE_CL_BRA) |=> flush_cycle_s)
        else $error("relative branch did not idle one cycle");

    bsf_sets_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        mem_we |-> wdata_q[instr_q[11:9]] && ((wdata_q | rdata_q) == wdata_q))
        else $error("set-file-bit data wrong");

    access_bank_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == bbe_pkg::BBE_ST_EXEC && phase == 2'h1 && !instr_q[8] && !ext_q)
        |-> eaddr_q[FILE_AW-1:8] == (instr_q[7:0] < `BBE_ACC_SPLIT ? 4'h0 : 4'hF))
        else $error("access bank address wrong");

    banked_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == bbe_pkg::BBE_ST_EXEC && phase == 2'h1 && instr_q[8])
        |-> eaddr_q == {bank_q, instr_q[7:0]})
        else $error("banked address wrong");

    indexed_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == bbe_pkg::BBE_ST_EXEC && phase == 2'h1 && !instr_q[8] && ext_q
         && instr_q[7:0] <= `BBE_IDX_LIMIT)
        |-> eaddr_q == idx_base_q + {{(FILE_AW-8){1'b0}}, instr_q[7:0]})
        else $error("indexed literal address wrong");

    bsf_one_cyc_a: assert property (@(posedge pclk) disable iff (!presetn)
        (exec_q4_s and cls_q == bbe_pkg::BBE_CL_BSF) |-> mem_we ##1
        state_q == bbe_pkg::BBE_ST_IDLE)
        else $error("set-file-bit not single cycle");
endmodule

// ==== hw/bbe_pkg.sv ====
// Types shared by the branch and bit-set executor
package bbe_pkg;

    // One-bit steps idle -> exec -> flush; flush -> idle changes both bits
    typedef enum logic [1:0] {
        BBE_ST_IDLE  = 2'h0,
        BBE_ST_EXEC  = 2'h1,
        BBE_ST_FLUSH = 2'h3
    } bbe_state_e;

    typedef enum logic [1:0] {
        BBE_CL_NONE = 2'h0,
        BBE_CL_BNZ  = 2'h1,
        BBE_CL_BRA  = 2'h2,
        BBE_CL_BSF  = 2'h3
    } bbe_class_e;

endpackage

// ==== hw/bbe_quarter.sv ====
// Free-running quarter-phase counter that splits the instruction cycle into Q1..Q4
`timescale 1ns/1ps
module bbe_quarter #(
    parameter int QW = 2
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Phase
    output logic [QW-1:0]      phase_q,
    output logic               last_q
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + {{(QW-1){1'b0}}, 1'b1};
        end
    end

    // Registered so consumers see a clean Q4 marker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 1'b0;
        end else begin
            last_q <= (phase_q == {{(QW-1){1'b1}}, 1'b0});
        end
    end
endmodule
